// ==== design/sleep_ctrl_pkg.sv ====
// constants, types and register layout for the sleep controller
// assumes a 32-bit AXI4-Lite bus; registers sit one per word at index*4
package sleep_ctrl_pkg;
  // register indices, byte address is index*4
  localparam logic [2:0] IDX_CONTROL_A_REGISTER = 3'h0;
  localparam logic [2:0] IDX_VREG  = 3'h1;
  localparam logic [2:0] IDX_KEY   = 3'h2;
  localparam logic [2:0] IDX_STAT  = 3'h3;
  localparam logic [2:0] IDX_STBY  = 3'h4;
  localparam int         ADDR_W    = 8;
  // field positions
  localparam int SEN_BIT   = 0;
  localparam int SLEEP_MODE_SELECT_LSB = 1;
  localparam int REGULATOR_POWER_MODE_LSB = 0;
  localparam int HTLL_BIT  = 4;
  localparam logic [7:0] CONTROL_A_REGISTER_RST = 8'h00;
  localparam logic [7:0] VREG_RST  = 8'h00;
  localparam logic [7:0] STBY_RST  = 8'h00;
  // sleep mode codes; every other code means no sleep
  localparam logic [2:0] SM_IDLE  = 3'h0;
  localparam logic [2:0] SM_STBY  = 3'h1;
  localparam logic [2:0] SM_PDOWN = 3'h2;
  // regulator power modes; other codes behave as automatic
  localparam logic [2:0] PM_AUTO = 3'h0;
  localparam logic [2:0] PM_FULL = 3'h1;
  // protection key (value arbitrary) and its window in bus writes
  localparam logic [7:0] CCP_KEY    = 8'hA5;
  localparam logic [2:0] CCP_WINDOW = 3'h4;
  localparam logic [2:0] WAKE_CYCLES = 3'h6;
  // peripheral classes
  localparam int PR_RTC = 0, PR_WDT = 1, PR_BOD = 2, PR_EVS = 3;
  localparam int PR_CCL = 4, PR_ACZ = 5, PR_ADC = 6, PR_TMR = 7;
  localparam logic [7:0] RUN_PDOWN = 8'h0F;
  localparam logic [7:0] RUN_STBY  = 8'h0E;
  // wake classes: port, vlm, mvio, rtc, twi match, logic, usart sof, other
  localparam logic [7:0] WK_IDLE  = 8'hFF;
  localparam logic [7:0] WK_STBY  = 8'h7F;
  localparam logic [7:0] WK_PD    = 8'h3F;
  localparam logic [7:0] WK_PD_HT = 8'h0F;
  localparam int         WK_OTHER = 7;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    ST_ACTIVE = 2'b00,
    ST_SLEEP  = 2'b01,
    ST_WAKE   = 2'b10
  } state_e;
  typedef struct packed {
    logic       htll;
    logic [2:0] regulator_power_mode;
    logic [2:0] sleep_mode_select;
    logic       sleep_enable_bit;
  } cfg_s;
endpackage

// ==== design/sleep_wake_filter.sv ====
// wake source mask for the mode being slept in
// assumes mode and configuration are stable while asleep
`timescale 1ns/1ns
module sleep_wake_filter
  import sleep_ctrl_pkg::*;
(
  input  wire logic [2:0] mode,      // sleep mode code
  input  wire logic       htll,      // hot low leakage enable
  input  wire logic [7:0] stby_keep, // run in standby per peripheral
  output logic      [7:0] mask       // wake classes allowed
);
  always_comb begin
    mask = 8'h00;
    if (mode == SM_IDLE) begin
      mask = WK_IDLE;
    end else if (mode == SM_STBY) begin
      mask = WK_STBY;
      mask[WK_OTHER] = stby_keep[PR_ADC] | stby_keep[PR_ACZ];
    end else if (mode == SM_PDOWN) begin
      mask = htll ? WK_PD_HT : WK_PD;
    end
  end
endmodule

// ==== design/sleep_power_gate.sv ====
// clock, peripheral and regulator gating for the current mode
// assumes clock status inputs come from the same clock domain
`timescale 1ns/1ns
module sleep_power_gate
  import sleep_ctrl_pkg::*;
(
  input  wire logic       sleeping,    // in sleep state
  input  wire logic [2:0] mode,        // mode slept in
  input  wire logic [7:0] stby_keep,   // run in standby per peripheral
  input  wire logic       hf_run_in_standby, // hf source run in standby
  input  wire logic       clk32k_only, // 32k oscillator is the only one
  input  wire logic [2:0] regulator_power_mode,       // regulator power mode
  output logic            hf_en,       // high-frequency clocks on
  output logic      [7:0] run,         // peripheral run enables
  output logic            reg_lp       // regulator low power
);
  logic stby;
  logic pdown;
  assign stby  = sleeping && mode == SM_STBY;
  assign pdown = sleeping && mode == SM_PDOWN;
  always_comb begin
    hf_en = !pdown;
    if (stby) begin
      hf_en = hf_run_in_standby || (|stby_keep);
    end
  end
  for (genvar i = 0; i < 8; i++) begin : g_run
    always_comb begin
      if (pdown) begin
        run[i] = RUN_PDOWN[i];
      end else if (stby) begin
        run[i] = RUN_STBY[i] | stby_keep[i];
      end else begin
        run[i] = 1'b1;
      end
    end
  end
  // full mode never drops; otherwise low when only 32k runs or deep sleep
  assign reg_lp = (regulator_power_mode != PM_FULL) && (clk32k_only || (sleeping && mode != SM_IDLE));
endmodule

// ==== design/sleep_controller.sv ====
// sleep controller: mode sequencing, wake-up timing, gating and registers
// assumes a CPU that pulses SLEEP_EXEC on its sleep instruction and
// same-clock interrupt and clock status inputs; AXI4-Lite slave for software
`timescale 1ns/1ns
module sleep_controller
  import sleep_ctrl_pkg::*;
(
  input  wire logic                         MCLK,          // 10 MHz peripheral clock
  input  wire logic                         RST,           // async reset, active high
  input  wire logic [sleep_ctrl_pkg::ADDR_W-1:0] AWADDR,   // write address
  input  wire logic                         AWVALID,       // write address valid
  output logic                              AWREADY,       // write address ready
  input  wire logic [31:0]                  WDATA,         // write data
  input  wire logic [3:0]                   WSTRB,         // write strobes
  input  wire logic                         WVALID,        // write data valid
  output logic                              WREADY,        // write data ready
  output logic [1:0]                        BRESP,         // write response
  output logic                              BVALID,        // write response valid
  input  wire logic                         BREADY,        // write response ready
  input  wire logic [sleep_ctrl_pkg::ADDR_W-1:0] ARADDR,   // read address
  input  wire logic                         ARVALID,       // read address valid
  output logic                              ARREADY,       // read address ready
  output logic [31:0]                       RDATA,         // read data
  output logic [1:0]                        RRESP,         // read response
  output logic                              RVALID,        // read data valid
  input  wire logic                         RREADY,        // read data ready
  input  wire logic                         SLEEP_EXEC,    // cpu sleep instruction pulse
  input  wire logic [7:0]                   IRQ_PEND,      // enabled pending irq per wake class
  input  wire logic                         DEBUG_BREAK,   // debugger break
  input  wire logic                         RESET_SRC,     // any reset source active
  input  wire logic                         CLK32K_ONLY,   // 32k oscillator is the only one
  input  wire logic                         HF_RUN_IN_STANDBY,   // hf source run in standby
  input  wire logic                         HF_OSC_READY,  // main clock source started
  input  wire logic                         REG_READY,     // regulator at full power
  output logic                              CPU_HALT,      // cpu must not execute
  output logic                              WAKE_DONE,     // pulse: take irq and resume
  output logic                              SYS_RESET_REQ, // device reset request
  output logic                              HF_CLK_EN,     // high-frequency clocks on
  output logic [7:0]                        PERIPH_RUN,    // peripheral run enables
  output logic                              REG_LOW_POWER, // regulator low power
  output logic                              REG_HTLL       // hot low leakage active
);
  import sleep_ctrl_pkg::*;

  cfg_s       cfg_q;
  logic [7:0] stby_q;
  logic [2:0] ccp_q;
  state_e     state_q;
  logic [2:0] mode_q;
  logic [2:0] cnt_q;
  logic       need_osc_q;
  logic       need_reg_q;
  logic       wake_done_q;
  logic       sys_rst_q;

  // bus write path
  logic       aw_got_q, w_got_q;
  logic [2:0] aw_idx_q;
  logic [7:0] wd_q;
  logic       ws_q;
  logic       aw_have, w_have, do_wr;
  logic [2:0] wr_idx;
  logic [7:0] wr_dat;
  logic       wr_stb;
  logic       wr_ok;
  logic [1:0] bresp_q;
  logic       bvalid_q;

  assign AWREADY = !aw_got_q && !bvalid_q;
  assign WREADY  = !w_got_q && !bvalid_q;
  assign aw_have = aw_got_q || (AWVALID && AWREADY);
  assign w_have  = w_got_q || (WVALID && WREADY);
  assign do_wr   = aw_have && w_have && !bvalid_q;
  assign wr_idx  = aw_got_q ? aw_idx_q : AWADDR[4:2];
  assign wr_dat  = w_got_q ? wd_q : WDATA[7:0];
  assign wr_stb  = w_got_q ? ws_q : WSTRB[0];
  assign wr_ok   = wr_idx <= IDX_STBY;

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      aw_got_q <= 1'b0;
      w_got_q  <= 1'b0;
      aw_idx_q <= 3'h0;
      wd_q     <= 8'h00;
      ws_q     <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else begin
      if (AWVALID && AWREADY) begin
        aw_got_q <= 1'b1;
        aw_idx_q <= AWADDR[4:2];
      end
      if (WVALID && WREADY) begin
        w_got_q <= 1'b1;
        wd_q    <= WDATA[7:0];
        ws_q    <= WSTRB[0];
      end
      if (do_wr) begin
        aw_got_q <= 1'b0;
        w_got_q  <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
      end
    end
  end
  assign BVALID = bvalid_q;
  assign BRESP  = bresp_q;

  // registers keep their values through sleep; only bus writes change them
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      cfg_q  <= {VREG_RST[HTLL_BIT], VREG_RST[REGULATOR_POWER_MODE_LSB+:3], CONTROL_A_REGISTER_RST[SLEEP_MODE_SELECT_LSB+:3], CONTROL_A_REGISTER_RST[SEN_BIT]};
      stby_q <= STBY_RST;
      ccp_q  <= 3'h0;
    end else if (do_wr && wr_stb) begin
      ccp_q <= (ccp_q != 3'h0) ? ccp_q - 3'h1 : 3'h0;
      unique case (wr_idx)
        IDX_CONTROL_A_REGISTER: begin
          cfg_q.sleep_enable_bit   <= wr_dat[SEN_BIT];
          cfg_q.sleep_mode_select <= wr_dat[SLEEP_MODE_SELECT_LSB+:3];
        end
        IDX_VREG: begin
          if (ccp_q != 3'h0) begin
            cfg_q.regulator_power_mode <= wr_dat[REGULATOR_POWER_MODE_LSB+:3];
            cfg_q.htll  <= wr_dat[HTLL_BIT];
          end
        end
        IDX_KEY: begin
          ccp_q <= (wr_dat == CCP_KEY) ? CCP_WINDOW : 3'h0;
        end
        IDX_STBY: begin
          stby_q <= wr_dat;
        end
        default: begin
        end
      endcase
    end
  end

  // bus read path
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic [7:0]  rd_val;
  logic [2:0]  rd_idx;
  assign ARREADY = !rvalid_q;
  assign rd_idx  = ARADDR[4:2];
  always_comb begin
    rd_val = 8'h00;
    unique case (rd_idx)
      IDX_CONTROL_A_REGISTER: rd_val = {4'h0, cfg_q.sleep_mode_select, cfg_q.sleep_enable_bit};
      IDX_VREG:  rd_val = {3'h0, cfg_q.htll, 1'b0, cfg_q.regulator_power_mode};
      IDX_STAT:  rd_val = {1'b0, REG_LOW_POWER, HF_CLK_EN, mode_q, state_q};
      IDX_STBY:  rd_val = stby_q;
      default:   rd_val = 8'h00;
    endcase
  end
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= RESP_OKAY;
    end else if (ARVALID && ARREADY) begin
      rvalid_q <= 1'b1;
      rdata_q  <= {24'h00_0000, rd_val};
      rresp_q  <= (rd_idx <= IDX_STBY) ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && RREADY) begin
      rvalid_q <= 1'b0;
    end
  end
  assign RVALID = rvalid_q;
  assign RDATA  = rdata_q;
  assign RRESP  = rresp_q;

  // mode sequencing
  logic [7:0] wake_mask;
  logic       sleeping;
  logic       mode_ok;
  logic       wake_hit;
  logic       hf_en, reg_lp;
  logic [7:0] run;
  logic       osc_ok, reg_ok;

  assign sleeping = state_q == ST_SLEEP;
  assign mode_ok  = cfg_q.sleep_mode_select == SM_IDLE || cfg_q.sleep_mode_select == SM_STBY || cfg_q.sleep_mode_select == SM_PDOWN;
  assign wake_hit = |(IRQ_PEND & wake_mask);
  assign osc_ok   = HF_OSC_READY || !need_osc_q;
  assign reg_ok   = REG_READY || !need_reg_q;

  sleep_wake_filter u_wake (
    .mode      (mode_q),
    .htll      (cfg_q.htll),
    .stby_keep (stby_q),
    .mask      (wake_mask)
  );

  sleep_power_gate u_gate (
    .sleeping    (sleeping),
    .mode        (mode_q),
    .stby_keep   (stby_q),
    .hf_run_in_standby (HF_RUN_IN_STANDBY),
    .clk32k_only (CLK32K_ONLY),
    .regulator_power_mode       (cfg_q.regulator_power_mode),
    .hf_en       (hf_en),
    .run         (run),
    .reg_lp      (reg_lp)
  );

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      state_q     <= ST_ACTIVE;
      mode_q      <= SM_IDLE;
      cnt_q       <= 3'h0;
      need_osc_q  <= 1'b0;
      need_reg_q  <= 1'b0;
      wake_done_q <= 1'b0;
    end else begin
      wake_done_q <= 1'b0;
      unique case (state_q)
        ST_ACTIVE: begin
          if (SLEEP_EXEC && cfg_q.sleep_enable_bit && mode_ok) begin
            state_q <= ST_SLEEP;
            mode_q  <= cfg_q.sleep_mode_select;
          end
        end
        ST_SLEEP: begin
          if (RESET_SRC) begin
            state_q <= ST_ACTIVE;
          end else if (wake_hit || DEBUG_BREAK) begin
            state_q    <= ST_WAKE;
            cnt_q      <= 3'h0;
            need_osc_q <= !HF_CLK_EN;
            need_reg_q <= REG_LOW_POWER;
          end
        end
        ST_WAKE: begin
          if (RESET_SRC) begin
            state_q <= ST_ACTIVE;
          end else if (cnt_q < WAKE_CYCLES - 3'h1) begin
            cnt_q <= cnt_q + 3'h1;
          end else if (osc_ok && reg_ok) begin
            state_q     <= ST_ACTIVE;
            wake_done_q <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_ACTIVE;
        end
      endcase
    end
  end

  // gating registered so clock enables never glitch
  logic       hf_q, lp_q, ht_q;
  logic [7:0] run_q;
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      hf_q      <= 1'b1;
      run_q     <= 8'hFF;
      lp_q      <= 1'b0;
      ht_q      <= 1'b0;
      sys_rst_q <= 1'b0;
    end else begin
      hf_q      <= hf_en;
      run_q     <= run;
      lp_q      <= reg_lp;
      ht_q      <= cfg_q.htll && sleeping && mode_q == SM_PDOWN;
      sys_rst_q <= RESET_SRC;
    end
  end

  assign CPU_HALT      = state_q != ST_ACTIVE;
  assign WAKE_DONE     = wake_done_q;
  assign SYS_RESET_REQ = sys_rst_q;
  assign HF_CLK_EN     = hf_q;
  assign PERIPH_RUN    = run_q;
  assign REG_LOW_POWER = lp_q;
  assign REG_HTLL      = ht_q;

  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  a_sleep_entry_cause: assert property ($rose(sleeping) |-> $past(SLEEP_EXEC && cfg_q.sleep_enable_bit && mode_ok))
    else $error("sleep entered without sleep instruction");
  a_halt_while_asleep: assert property (sleeping |-> CPU_HALT)
    else $error("cpu running while asleep");
  a_wake_six_cycles: assert property (sleeping && !RESET_SRC && wake_hit |=> CPU_HALT [*6])
    else $error("wake-up shorter than six cycles");
  a_reset_ends_sleep: assert property (sleeping && RESET_SRC |=> !CPU_HALT && SYS_RESET_REQ)
    else $error("reset did not end sleep");
  a_debug_wakes: assert property (sleeping && DEBUG_BREAK && !RESET_SRC |=> state_q == ST_WAKE)
    else $error("debug break did not wake");
  a_no_wake_stays: assert property (sleeping && !wake_hit && !DEBUG_BREAK && !RESET_SRC |=> sleeping)
    else $error("woke without cause");
  a_pdown_hf_off: assert property (sleeping && mode_q == SM_PDOWN ##1 sleeping |-> !HF_CLK_EN)
    else $error("fast clock on in power-down");
  a_idle_all_run: assert property (sleeping && mode_q == SM_IDLE |=> HF_CLK_EN && PERIPH_RUN == 8'hFF)
    else $error("peripheral stopped in idle");
  a_full_no_lowpower: assert property (cfg_q.regulator_power_mode == PM_FULL |=> !REG_LOW_POWER)
    else $error("regulator low power in full mode");
  a_sen_kept_wake: assert property (WAKE_DONE |-> cfg_q.sleep_enable_bit && $past(state_q) == ST_WAKE)
    else $error("enable lost across wake");
  a_bad_mode_no_sleep: assert property (!mode_ok && !sleeping && state_q == ST_ACTIVE |=> state_q == ST_ACTIVE)
    else $error("unused mode code slept");
  a_stby_keep_run: assert property (sleeping && mode_q == SM_STBY |=> PERIPH_RUN == (RUN_STBY | $past(stby_q)))
    else $error("standby run enables differ from keep bits");
  a_htll_pdown_only: assert property (REG_HTLL |-> $past(sleeping && mode_q == SM_PDOWN && cfg_q.htll))
    else $error("hot leakage active outside power-down");

  c_enter_pdown: cover property (state_q == ST_ACTIVE ##1 sleeping && mode_q == SM_PDOWN);
  c_irq_wake: cover property (sleeping && wake_hit ##[6:40] WAKE_DONE);
  c_debug_wake: cover property (sleeping && DEBUG_BREAK);
  c_reset_sleep: cover property (sleeping && RESET_SRC);
  c_stby_keep_wake: cover property (sleeping && mode_q == SM_STBY && wake_hit);
endmodule

// ==== verification/cpu_sleep_model.sv ====
// cpu partner: issues the sleep instruction and holds enabled interrupt requests
// assumes the bench asks for sleep and raises interrupt classes through its inputs
`timescale 1ns/1ns
module cpu_sleep_model
  import sleep_ctrl_pkg::*;
(
  input  wire logic       MCLK,          // peripheral clock
  input  wire logic       RST,           // async reset, active high
  input  wire logic       sleep_req,     // bench asks for a sleep instruction
  input  wire logic [7:0] irq_raise,     // bench raises enabled interrupt classes
  input  wire logic       CPU_HALT,      // cpu may not execute
  input  wire logic       WAKE_DONE,     // take irq and resume
  input  wire logic       SYS_RESET_REQ, // device reset
  output logic            SLEEP_EXEC,    // sleep instruction pulse
  output logic      [7:0] IRQ_PEND,      // pending enabled irq per class
  output int              wakes          // interrupts serviced after wake
);
  // a halted cpu cannot execute another sleep instruction
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) SLEEP_EXEC <= 1'b0;
    else SLEEP_EXEC <= sleep_req && !CPU_HALT && !SLEEP_EXEC;
  end
  // the handler clears all pending flags on wake, as does a device reset; only classes raised that cycle stay
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      IRQ_PEND <= 8'h00;
      wakes    <= 0;
    end else if (WAKE_DONE || SYS_RESET_REQ) begin
      IRQ_PEND <= irq_raise;
      wakes    <= wakes + (WAKE_DONE ? 1 : 0);
    end else IRQ_PEND <= IRQ_PEND | irq_raise;
  end
endmodule

// ==== verification/sleep_controller_tb.sv ====
// testbench for the sleep controller: registers over AXI4-Lite, mode entry, wake and gating
// assumes the cpu partner model and the design package; one 10 MHz clock
`timescale 1ns/1ns
module sleep_controller_tb;
  import sleep_ctrl_pkg::*;
  logic        mclk, rst, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr, araddr, irq_pend, irq_raise, periph_run;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        sleep_exec, debug_break, reset_src, clk32k_only, hf_run_in_standby, hf_osc_ready, reg_ready;
  logic        sleep_req, cpu_halt, wake_done, sys_reset_req, hf_clk_en, reg_low_power, reg_htll;
  int          miscompares = 0, n_compared = 0, cycles = 0, wakes, n;

  sleep_controller i_dut (.MCLK(mclk), .RST(rst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
    .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp), .BVALID(bvalid),
    .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready), .SLEEP_EXEC(sleep_exec), .IRQ_PEND(irq_pend), .DEBUG_BREAK(debug_break),
    .RESET_SRC(reset_src), .CLK32K_ONLY(clk32k_only), .HF_RUN_IN_STANDBY(hf_run_in_standby), .HF_OSC_READY(hf_osc_ready),
    .REG_READY(reg_ready), .CPU_HALT(cpu_halt), .WAKE_DONE(wake_done), .SYS_RESET_REQ(sys_reset_req),
    .HF_CLK_EN(hf_clk_en), .PERIPH_RUN(periph_run), .REG_LOW_POWER(reg_low_power), .REG_HTLL(reg_htll));
  cpu_sleep_model i_cpu (.MCLK(mclk), .RST(rst), .sleep_req(sleep_req), .irq_raise(irq_raise),
    .CPU_HALT(cpu_halt), .WAKE_DONE(wake_done), .SYS_RESET_REQ(sys_reset_req), .SLEEP_EXEC(sleep_exec),
    .IRQ_PEND(irq_pend), .wakes(wakes));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // a hang ends the run as a failure
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // write and data are offered together and each is dropped once taken
  task automatic axi_wr(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge mclk);
    awaddr  <= {3'h0, idx, 2'h0};
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    check("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic axi_rd(input logic [2:0] idx, input logic [7:0] d, input logic [1:0] er);
    @(posedge mclk);
    araddr  <= {3'h0, idx, 2'h0};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    forever begin
      @(posedge mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    check("rdata", {24'h0, d}, rdata);
    check("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  // the model needs one edge to issue the instruction, gating lands two edges later
  task automatic enter_sleep();
    @(posedge mclk);
    sleep_req <= 1'b1;
    @(posedge mclk);
    sleep_req <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  // counts edges from the cause until the wake pulse; 50 means no wake
  task automatic wait_wake(output int k);
    k = 0;
    while (wake_done !== 1'b1 && k < 50) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask
  task automatic wake_time(input logic [7:0] cls, output int k);
    @(posedge mclk);
    irq_raise <= cls;
    @(posedge mclk);
    irq_raise <= 8'h00;
    wait_wake(k);
  endtask

  initial begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, sleep_req, debug_break, reset_src} = 8'h00;
    {awaddr, araddr, irq_raise, wdata} = 56'h0;
    {clk32k_only, hf_run_in_standby, hf_osc_ready, reg_ready} = 4'h3;
    wstrb = 4'h1;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    axi_rd(IDX_CONTROL_A_REGISTER, 8'h00, RESP_OKAY);
    axi_rd(IDX_VREG, 8'h00, RESP_OKAY);
    axi_rd(IDX_STBY, 8'h00, RESP_OKAY);
    axi_rd(IDX_STAT, 8'h20, RESP_OKAY);
    axi_rd(3'h5, 8'h00, RESP_SLVERR);
    // idle: configuration alone does not sleep, the instruction does
    axi_wr(IDX_CONTROL_A_REGISTER, {4'h0, SM_IDLE, 1'b1}, RESP_OKAY);
    repeat (10) @(posedge mclk);
    #1;
    check("halt_config_only", 32'h0, cpu_halt);
    enter_sleep();
    check("halt_idle", 32'h1, cpu_halt);
    check("gate_idle", 32'h1FF, {reg_low_power, hf_clk_en, periph_run});
    wake_time(8'h80, n);
    check("wake_idle", 32'd7, n);
    axi_rd(IDX_CONTROL_A_REGISTER, {4'h0, SM_IDLE, 1'b1}, RESP_OKAY);
    check("serviced", 32'd1, wakes);
    // standby with nothing kept: other class masked, wake waits for clock and regulator
    axi_wr(IDX_CONTROL_A_REGISTER, {4'h0, SM_STBY, 1'b1}, RESP_OKAY);
    hf_osc_ready <= 1'b0;
    reg_ready    <= 1'b0;
    enter_sleep();
    check("gate_stby", 32'h20E, {reg_low_power, hf_clk_en, periph_run});
    // a fast source marked run in standby brings the fast clock back while asleep
    hf_run_in_standby <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check("hf_run_in_standby", 32'h1, hf_clk_en);
    hf_run_in_standby <= 1'b0;
    wake_time(8'h80, n);
    check("stby_masked", 32'd50, n);
    wake_time(8'h40, n);
    check("stby_wait_ready", 32'd50, n);
    hf_osc_ready <= 1'b1;
    reg_ready    <= 1'b1;
    wait_wake(n);
    check("stby_ready_wake", 32'h1, n >= 1 && n <= 3);
    // standby keeping the converter: its run enable and the fast clock stay up
    axi_wr(IDX_STBY, 8'h40, RESP_OKAY);
    enter_sleep();
    check("gate_keep", 32'h34E, {reg_low_power, hf_clk_en, periph_run});
    wake_time(8'h80, n);
    check("wake_keep", 32'd7, n);
    // protected regulator control
    axi_wr(IDX_VREG, 8'h10, RESP_OKAY);
    axi_rd(IDX_VREG, 8'h00, RESP_OKAY);
    axi_wr(IDX_KEY, CCP_KEY, RESP_OKAY);
    axi_wr(IDX_VREG, 8'h10, RESP_OKAY);
    axi_rd(IDX_VREG, 8'h10, RESP_OKAY);
    // power-down with hot leakage; a usart start-of-frame wake stays masked meanwhile
    axi_wr(IDX_CONTROL_A_REGISTER, {4'h0, SM_PDOWN, 1'b1}, RESP_OKAY);
    enter_sleep();
    check("gate_pdown", 32'h60F, {reg_htll, reg_low_power, hf_clk_en, periph_run});
    wake_time(8'h40, n);
    check("pdown_masked", 32'd50, n);
    wake_time(8'h08, n);
    check("wake_pdown", 32'd7, n);
    // running on the 32k oscillator alone lets the regulator drop even when active
    clk32k_only <= 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    check("lp_32k_only", 32'h1, reg_low_power);
    clk32k_only <= 1'b0;
    // full regulator mode stays at full power while asleep; a debug break wakes
    axi_wr(IDX_KEY, CCP_KEY, RESP_OKAY);
    axi_wr(IDX_VREG, {5'h0, PM_FULL}, RESP_OKAY);
    axi_wr(IDX_CONTROL_A_REGISTER, {4'h0, SM_STBY, 1'b1}, RESP_OKAY);
    enter_sleep();
    check("reg_full", 32'h0, reg_low_power);
    @(posedge mclk);
    debug_break <= 1'b1;
    wait_wake(n);
    debug_break <= 1'b0;
    check("wake_debug", 32'd7, n);
    // an unused mode code is no sleep
    axi_wr(IDX_CONTROL_A_REGISTER, 8'h07, RESP_OKAY);
    enter_sleep();
    check("halt_bad_mode", 32'h0, cpu_halt);
    // no enabled interrupt: asleep until a reset source
    axi_wr(IDX_CONTROL_A_REGISTER, {4'h0, SM_IDLE, 1'b1}, RESP_OKAY);
    enter_sleep();
    repeat (100) @(posedge mclk);
    #1;
    check("halt_forever", 32'h1, cpu_halt);
    @(posedge mclk);
    reset_src <= 1'b1;
    @(posedge mclk);
    #1;
    check("reset_exit", 32'h1, {cpu_halt, sys_reset_req, wake_done} === 3'b010);
    reset_src <= 1'b0;
    axi_rd(IDX_STBY, 8'h40, RESP_OKAY);
    print_verdict();
  end
endmodule
